/* File: core/bpms_pkg.sv */
// Package with register map, field layout and mode types of the sequencer.
package bpms_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // --------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------
  localparam int CTRL_DISP_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_METRO_BIT = 2;
  localparam int CTRL_PLL_BIT = 3;
  localparam int CTRL_BLINK_LSB = 4;

  // --------------------------------------------------------------
  // Status fields
  // --------------------------------------------------------------
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_GOOD_BIT = 2;
  localparam int STAT_PSF_LSB = 4;
  localparam int STAT_WAKE_BIT = 8;

  // --------------------------------------------------------------
  // Values loaded on restart from a low-power mode
  // --------------------------------------------------------------
  localparam logic CFG_METRO_RST = 1'b1;
  localparam logic CFG_PLL_RST = 1'b1;
  localparam logic [1:0] CFG_BLINK_RST = 2'h0;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    full_power_mode,
    battery_active_mode,
    display_only_mode,
    lowest_power_mode
  } bpms_mode_t;

  typedef struct packed {
    logic [1:0] blink_en;
    logic pll_fast;
    logic metro_en;
  } bpms_cfg_t;

endpackage

/* File: core/bpms_top.sv */
// Power-mode sequencer with APB control and status registers.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module bpms_top #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_above_supply_thr,
  input wire logic i_above_brownout_thr,
  input wire logic i_wake_timer,
  input wire logic i_pushbutton_input,
  input wire logic [2:0] i_wake_pins,
  input wire logic [1:0] i_rx_pins,
  output logic o_irq,
  output logic [2:0] o_power_state_field,
  output logic o_cpu_run,
  output logic o_cpu_restart,
  output logic o_periph_en,
  output logic o_rail_on,
  output logic o_rail_from_battery,
  output logic o_display_on,
  output logic [1:0] o_blink_en,
  output logic o_metro_en,
  output logic o_pll_fast
);

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync3_r;
  wire [8:0] pins_in = {i_rx_pins, i_wake_pins, i_pushbutton_input,
                        i_wake_timer, i_above_brownout_thr,
                        i_above_supply_thr};

  // The synchronisers carry no reset: they flush while reset is held, so
  // a high supply flag is not seen as lost, and no false edge appears.
  always_ff @(posedge i_clk) begin
    sync1_r <= pins_in;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  // The comparator output is the supply-good flag itself.
  wire supply_good = sync2_r[0];
  wire above_brownout = sync2_r[1];
  wire [8:0] rise = sync2_r & ~sync3_r;
  wire [8:0] fall = ~sync2_r & sync3_r;
  // Receive activity is any edge; the other sources wake on a rise.
  wire wake_ev = |rise[6:2] | (|(rise[8:7] | fall[8:7]));

  // --------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  wire setup = i_psel & ~i_penable & ~pready_r;
  wire hit_ctrl = i_paddr == ADDR_W'(bpms_pkg::CTRL_OFS);
  wire hit_stat = i_paddr == ADDR_W'(bpms_pkg::STAT_OFS);
  wire wr_ctrl = i_psel & i_penable & pready_r & i_pwrite & hit_ctrl;
  wire disp_cmd = wr_ctrl & i_pwdata[bpms_pkg::CTRL_DISP_BIT];
  wire sleep_cmd = wr_ctrl & i_pwdata[bpms_pkg::CTRL_SLEEP_BIT];

  // --------------------------------------------------------------
  // Mode sequencer
  // --------------------------------------------------------------
  bpms_pkg::bpms_mode_t mode_r;
  bpms_pkg::bpms_mode_t mode_nxt;
  logic wake_r;
  bpms_pkg::bpms_cfg_t cfg_r;
  bpms_pkg::bpms_cfg_t cfg_nxt;

  wire in_low = (mode_r == bpms_pkg::display_only_mode) |
                (mode_r == bpms_pkg::lowest_power_mode);
  // Supply return has priority over every other cause.
  wire to_full = (mode_r != bpms_pkg::full_power_mode) & supply_good;
  wire restart = in_low & (mode_nxt != mode_r);

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      bpms_pkg::full_power_mode: begin
        if (!supply_good || !above_brownout) begin
          mode_nxt = bpms_pkg::battery_active_mode;
        end else if (sleep_cmd) begin
          mode_nxt = bpms_pkg::lowest_power_mode;
        end else if (disp_cmd) begin
          mode_nxt = bpms_pkg::display_only_mode;
        end
      end
      bpms_pkg::battery_active_mode: begin
        if (supply_good) begin
          mode_nxt = bpms_pkg::full_power_mode;
        end else if (sleep_cmd) begin
          mode_nxt = bpms_pkg::lowest_power_mode;
        end else if (disp_cmd) begin
          mode_nxt = bpms_pkg::display_only_mode;
        end
      end
      bpms_pkg::display_only_mode, bpms_pkg::lowest_power_mode: begin
        if (supply_good) begin
          mode_nxt = bpms_pkg::full_power_mode;
        end else if (wake_ev) begin
          mode_nxt = bpms_pkg::battery_active_mode;
        end
      end
    endcase
  end

  // Restart from a low-power mode sets metrology on, PLL fast and blink off.
  always_comb begin
    cfg_nxt = cfg_r;
    if (restart) begin
      cfg_nxt.blink_en = bpms_pkg::CFG_BLINK_RST;
      cfg_nxt.pll_fast = bpms_pkg::CFG_PLL_RST;
      cfg_nxt.metro_en = bpms_pkg::CFG_METRO_RST;
    end else if (wr_ctrl) begin
      cfg_nxt.metro_en = i_pwdata[bpms_pkg::CTRL_METRO_BIT];
      cfg_nxt.pll_fast = i_pwdata[bpms_pkg::CTRL_PLL_BIT];
      cfg_nxt.blink_en = i_pwdata[bpms_pkg::CTRL_BLINK_LSB +: 2];
    end
  end

  wire nxt_full = mode_nxt == bpms_pkg::full_power_mode;
  wire nxt_batt = mode_nxt == bpms_pkg::battery_active_mode;
  wire nxt_disp = mode_nxt == bpms_pkg::display_only_mode;
  wire nxt_sleep = mode_nxt == bpms_pkg::lowest_power_mode;
  wire mode_chg = mode_nxt != mode_r;
  wire irq_ev = mode_chg & (nxt_full | (nxt_batt & ~in_low));

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_r <= bpms_pkg::full_power_mode;
      cfg_r <= '0;
      wake_r <= 1'b0;
      o_irq <= 1'b0;
      o_power_state_field <= 3'h0;
      o_cpu_run <= 1'b0;
      o_cpu_restart <= 1'b0;
      o_periph_en <= 1'b0;
      o_rail_on <= 1'b0;
      o_rail_from_battery <= 1'b0;
      o_display_on <= 1'b0;
      o_blink_en <= 2'h0;
      o_metro_en <= 1'b0;
      o_pll_fast <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      // Battery entry from full power keeps metrology and PLL settings; wake from a low-power mode reloads them.
      cfg_r <= cfg_nxt;
      // A wake event in the same cycle as sleep entry is kept.
      wake_r <= wake_ev | (wake_r & ~(nxt_sleep & mode_chg));
      o_irq <= irq_ev;
      o_power_state_field <= {~supply_good, mode_nxt};
      o_cpu_run <= nxt_full | nxt_batt;
      o_cpu_restart <= restart;
      o_periph_en <= nxt_full | nxt_batt;
      o_rail_on <= nxt_full | nxt_batt;
      o_rail_from_battery <= ~nxt_full;
      o_display_on <= ~nxt_sleep;
      o_blink_en <= nxt_disp ? cfg_nxt.blink_en : 2'h0;
      o_metro_en <= cfg_nxt.metro_en;
      o_pll_fast <= cfg_nxt.pll_fast;
    end
  end

  // --------------------------------------------------------------
  // APB slave without wait states: ready in the first access cycle
  // --------------------------------------------------------------
  wire [31:0] stat_word = 32'(wake_r) << bpms_pkg::STAT_WAKE_BIT |
                          32'(o_power_state_field) << bpms_pkg::STAT_PSF_LSB |
                          32'(supply_good) << bpms_pkg::STAT_GOOD_BIT |
                          32'(mode_r) << bpms_pkg::STAT_MODE_LSB;
  wire [31:0] ctrl_word = 32'(cfg_r.blink_en) << bpms_pkg::CTRL_BLINK_LSB |
                          32'(cfg_r.pll_fast) << bpms_pkg::CTRL_PLL_BIT |
                          32'(cfg_r.metro_en) << bpms_pkg::CTRL_METRO_BIT;
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      prdata_r <= setup ? rd_word : 32'h0000_0000;
      pslverr_r <= setup & ~(hit_ctrl | (hit_stat & ~i_pwrite));
    end
  end

  assign o_pready = pready_r;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  localparam bpms_pkg::bpms_mode_t FULL = bpms_pkg::full_power_mode;
  localparam bpms_pkg::bpms_mode_t BATT = bpms_pkg::battery_active_mode;
  localparam bpms_pkg::bpms_mode_t DISP = bpms_pkg::display_only_mode;
  localparam bpms_pkg::bpms_mode_t LOWP = bpms_pkg::lowest_power_mode;

  // --------------------------------------------------------------
  // Mode assertions
  // --------------------------------------------------------------
  a_flag_clears: assert property (
    !supply_good |=> o_power_state_field[2])
    else $error("supply flag not cleared");
  a_loss_battery: assert property (
    mode_r == FULL && !supply_good |=>
      mode_r == BATT && o_irq && o_power_state_field == 3'h5)
    else $error("supply loss not handled");
  a_cpu_keeps: assert property (
    mode_r == FULL ##1 mode_r == BATT |-> o_cpu_run && !o_cpu_restart)
    else $error("processor disturbed on brownout");
  a_cfg_hold: assert property (
    mode_r == BATT && !wr_ctrl |=> $stable(cfg_r))
    else $error("config changed in battery mode");
  a_return_full: assert property (
    mode_r != FULL && supply_good |=>
      mode_r == FULL && o_irq && o_power_state_field[1:0] == 2'h0)
    else $error("no return to full power");
  a_full_steady: assert property (
    mode_r == FULL ##1 mode_r == FULL |-> o_cpu_run && o_rail_on &&
      !o_rail_from_battery)
    else $error("full power outputs wrong");
  a_wake_batt: assert property (
    (mode_r == DISP || mode_r == LOWP) && !supply_good && wake_ev
      |=> mode_r == BATT)
    else $error("wake event ignored");
  a_wake_no_irq: assert property (
    (mode_r == DISP || mode_r == LOWP) && !supply_good
      |=> !o_irq)
    else $error("interrupt raised on wake");
  a_periph_on: assert property (
    mode_r == BATT |-> o_periph_en && o_rail_from_battery)
    else $error("peripherals off in battery mode");
  a_batt_display: assert property (
    mode_r == BATT |-> o_display_on && o_rail_on)
    else $error("display off in battery mode");
  a_disp_accept: assert property (
    mode_r == BATT && !supply_good && disp_cmd && !sleep_cmd
      |=> mode_r == DISP && !o_cpu_run)
    else $error("display request refused");
  a_disp_anytime: assert property (
    mode_r == FULL && supply_good && above_brownout && disp_cmd &&
      !sleep_cmd ##1 supply_good |=> mode_r == FULL && o_cpu_restart && o_irq)
    else $error("display request with supply wrong");
  a_disp_outs: assert property (
    mode_r == DISP |-> !o_cpu_run && !o_rail_on && o_display_on &&
      o_blink_en == cfg_r.blink_en)
    else $error("display mode outputs wrong");
  a_blink_off: assert property (
    mode_r != DISP |-> o_blink_en == 2'h0)
    else $error("blink outside display mode");
  a_disp_restart: assert property (
    mode_r == DISP ##1 mode_r != DISP |-> o_cpu_restart && o_pll_fast)
    else $error("no restart after display mode");
  a_restart_pulse: assert property (
    o_cpu_restart |=> !o_cpu_restart)
    else $error("restart longer than one cycle");
  a_brownout_rail: assert property (
    mode_r == FULL && !above_brownout |=> mode_r == BATT && o_rail_from_battery)
    else $error("brownout not handled");
  a_sleep_entry: assert property (
    mode_r == BATT && !supply_good && sleep_cmd |=> mode_r == LOWP && !o_rail_on)
    else $error("sleep request refused");
  a_sleep_rail: assert property (
    mode_r == LOWP |-> !o_rail_on && !o_cpu_run && !o_display_on)
    else $error("rail on during sleep");
  a_sleep_stays: assert property (
    mode_r == LOWP && !supply_good && !wake_ev |=> mode_r == LOWP)
    else $error("sleep left without cause");
  a_sleep_powered: assert property (
    mode_r == FULL && supply_good && above_brownout && sleep_cmd &&
      !wake_ev |=> mode_r == LOWP && !wake_r)
    else $error("sleep from full power wrong");
  a_sleep_wake: assert property (
    mode_r == FULL && supply_good && above_brownout && sleep_cmd
      ##1 supply_good |=> mode_r == FULL && o_cpu_restart && o_irq)
    else $error("no wake after powered sleep");
  a_sleep_return: assert property (
    mode_r == LOWP && supply_good |=> mode_r == FULL && o_cpu_restart)
    else $error("no restart on supply return");
  a_state_field: assert property (
    o_power_state_field[1:0] == mode_r)
    else $error("state field differs from mode");

  // --------------------------------------------------------------
  // Bus assertions and mode covers
  // --------------------------------------------------------------
  a_slave_pulse: assert property (
    o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_slave_error: assert property (
    o_pslverr |-> o_pready)
    else $error("error without ready");
  a_read_idle: assert property (
    !o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside access");

  c_loss: cover property (mode_r == FULL ##1 mode_r == BATT);
  c_disp: cover property (mode_r == DISP ##1 mode_r == BATT);
  c_sleep: cover property (mode_r == LOWP ##1 mode_r == FULL);
  c_back: cover property (mode_r == BATT ##1 mode_r == FULL);
  c_bounce: cover property (mode_r == FULL ##1 mode_r == DISP ##1 mode_r == FULL);

endmodule

/* File: tb/bpms_fw_model.sv */
// Firmware policy model that composes control words for the sequencer.
`timescale 1ns/10ps
module bpms_fw_model (
  input wire logic [1:0] i_req,
  input wire logic [1:0] i_blink,
  output logic [31:0] o_ctrl_word
);
  // Metrology off and PLL slow go out with every low-power request.
  assign o_ctrl_word = {26'h0, i_blink, 1'h0, 1'h0, i_req};
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the power-mode sequencer.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic sup;
    logic [6:0] wk;
    logic [5:0] cw;
    logic [1:0] md;
  } bpms_row_t;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, fw_word;
  logic pready, pslverr, er, sup = 1'h1, irq, run, rsp, per, rail, railb;
  logic disp, metro, pll;
  logic [6:0] wk = 7'h0;
  logic [2:0] psf;
  logic [1:0] blink, fw_req = 2'h0, fw_blink = 2'h0;
  int err_total = 0, n_tests = 0, n_irq = 0, n_rsp = 0, s_irq, s_rsp;
  bpms_row_t rows [22] = '{
    '{1'h1, 7'h00, 6'h00, 2'h0}, '{1'h0, 7'h00, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h01, 2'h2}, '{1'h0, 7'h01, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h02, 2'h3}, '{1'h0, 7'h02, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h01, 2'h2}, '{1'h0, 7'h04, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h02, 2'h3}, '{1'h0, 7'h08, 6'h00, 2'h1},
    '{1'h0, 7'h08, 6'h01, 2'h2}, '{1'h0, 7'h00, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h02, 2'h3}, '{1'h0, 7'h20, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h01, 2'h2}, '{1'h0, 7'h40, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h02, 2'h3}, '{1'h0, 7'h10, 6'h00, 2'h1},
    '{1'h1, 7'h00, 6'h00, 2'h0}, '{1'h0, 7'h00, 6'h00, 2'h1},
    '{1'h0, 7'h00, 6'h02, 2'h3}, '{1'h1, 7'h00, 6'h00, 2'h0}};

  bpms_top dut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_above_supply_thr(sup),
    .i_above_brownout_thr(sup), .i_wake_timer(wk[6]),
    .i_pushbutton_input(wk[5]), .i_wake_pins(wk[2:0]), .i_rx_pins(wk[4:3]),
    .o_irq(irq), .o_power_state_field(psf), .o_cpu_run(run),
    .o_cpu_restart(rsp), .o_periph_en(per), .o_rail_on(rail),
    .o_rail_from_battery(railb), .o_display_on(disp), .o_blink_en(blink),
    .o_metro_en(metro), .o_pll_fast(pll));
  bpms_fw_model fw (.i_req(fw_req), .i_blink(fw_blink), .o_ctrl_word(fw_word));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Pulse counters let the tests check one-cycle events after the fact.
  always @(posedge clk) begin
    n_irq <= n_irq + int'(irq === 1'h1);
    n_rsp <= n_rsp + int'(rsp === 1'h1);
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (pready !== 1'h1) begin
      err_total++;
      complete_run();
    end
    @(posedge clk);
  endtask

  task automatic wait_mode(input logic [1:0] m, input logic s);
    int k;
    k = 0;
    do begin
      apb(1'h0, bpms_pkg::STAT_OFS, 32'h0);
      k++;
    end while (rd[1:0] !== m && k < 40);
    chk("mode", 32'(m), 32'(rd[1:0]));
    chk("good", 32'(s), 32'(rd[bpms_pkg::STAT_GOOD_BIT]));
    chk("field", 32'({~s, m}), 32'(psf));
    if (rd[1:0] !== m) begin
      complete_run();
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("reset outs", 32'h0, 32'({psf, run, irq, railb}));
    apb(1'h0, bpms_pkg::CTRL_OFS, 32'h0);
    chk("reset ctrl", 32'h0, rd);
    foreach (rows[i]) begin
      sup <= rows[i].sup;
      wk <= rows[i].wk;
      if (rows[i].cw != 6'h0) begin
        apb(1'h1, bpms_pkg::CTRL_OFS, 32'(rows[i].cw));
      end
      wait_mode(rows[i].md, rows[i].sup);
      $display("row %0d done", i);
    end
    for (int c = 1; c < 3; c++) begin
      s_irq = n_irq;
      s_rsp = n_rsp;
      apb(1'h1, bpms_pkg::CTRL_OFS, 32'(c));
      repeat (10) @(posedge clk);
      chk("bounce restart", 32'(s_rsp + 1), 32'(n_rsp));
      chk("bounce irq", 32'(s_irq + 1), 32'(n_irq));
      wait_mode(2'h0, 1'h1);
      $display("bounce %0d done", c);
    end
    apb(1'h1, bpms_pkg::CTRL_OFS, 32'h0c);
    s_irq = n_irq;
    sup <= 1'h0;
    wait_mode(2'h1, 1'h0);
    chk("battery outs", 32'h1f, 32'({run, metro, pll, per, railb}));
    chk("loss irq", 32'(s_irq + 1), 32'(n_irq));
    fw_req <= 2'h1;
    fw_blink <= 2'h3;
    @(posedge clk);
    apb(1'h1, bpms_pkg::CTRL_OFS, fw_word);
    wait_mode(2'h2, 1'h0);
    chk("display outs", 32'h13, 32'({run, rail, disp, metro, pll, blink}));
    s_irq = n_irq;
    s_rsp = n_rsp;
    wk <= 7'h01;
    wait_mode(2'h1, 1'h0);
    chk("wake restart", 32'(s_rsp + 1), 32'(n_rsp));
    chk("wake irq", 32'(s_irq), 32'(n_irq));
    chk("restart cfg", {29'h0, bpms_pkg::CFG_METRO_RST, bpms_pkg::CFG_PLL_RST,
      1'h0}, 32'({metro, pll, blink != 2'h0}));
    apb(1'h0, bpms_pkg::CTRL_OFS, 32'h0);
    chk("restart ctrl", {26'h0, bpms_pkg::CFG_BLINK_RST, bpms_pkg::CFG_PLL_RST,
      bpms_pkg::CFG_METRO_RST, 2'h0}, rd);
    $display("display case done");
    wk <= 7'h00;
    apb(1'h1, bpms_pkg::CTRL_OFS, 32'h2);
    repeat (20) @(posedge clk);
    wait_mode(2'h3, 1'h0);
    chk("sleep outs", 32'h0, 32'({rail, disp, run}));
    s_irq = n_irq;
    s_rsp = n_rsp;
    sup <= 1'h1;
    wait_mode(2'h0, 1'h1);
    chk("return restart", 32'(s_rsp + 1), 32'(n_rsp));
    chk("return irq", 32'(s_irq + 1), 32'(n_irq));
    $display("sleep case done");
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("soft reset outs", 32'h0, 32'({psf, run, irq, railb}));
    apb(1'h0, bpms_pkg::CTRL_OFS, 32'h0);
    chk("soft reset ctrl", 32'h0, rd);
    wait_mode(2'h0, 1'h1);
    $display("soft reset case done");
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    apb(1'h1, bpms_pkg::STAT_OFS, 32'hff);
    chk("status write", 32'h1, 32'(er));
    $display("refusal case done");
    complete_run();
  end
endmodule
